// ### rtl/isbx_core.sv
// isbx_core: executes decrement-skip, increment-skip, increment, or-literal and branch
// assumes: fetch presents one word per cycle with insn_valid_i; file data for the
// addressed register is returned combinationally on f_rdata_i in the same cycle;
// a file write leaves through a register, so the file sees it one edge after execute
// and a word that reads the same file in the very next slot gets the old value
`timescale 1ns/10ps
module isbx_core
(
  input  wire logic                        clk_i,        // core clock, 100 MHz
  input  wire logic                        rst_b_i,      // async reset, active low
  input  wire logic                        insn_valid_i, // fetched word is valid
  input  wire logic [isbx_pkg::INSN_W-1:0] insn_i,       // fetched instruction word
  input  wire logic [isbx_pkg::DATA_W-1:0] f_rdata_i,    // addressed file contents
  input  wire logic [isbx_pkg::DATA_W-1:0] upper_pc_latch_i, // upper pc latch
  output logic [isbx_pkg::FADR_W-1:0]      f_raddr_o,    // file read address
  output logic                             f_we_o,       // file write strobe
  output logic [isbx_pkg::FADR_W-1:0]      f_waddr_o,    // file write address
  output logic [isbx_pkg::DATA_W-1:0]      f_wdata_o,    // file write data
  output logic [isbx_pkg::DATA_W-1:0]      acc_o,        // working register
  output logic                             zero_o,       // zero flag
  output logic [isbx_pkg::PC_W-1:0]        pc_o,         // program counter
  output logic                             insn_ack_o,   // word consumed this cycle
  output logic                             flush_o       // fetched word discarded
);

  // ==========================================================
  // helpers
  // zero test used by every flag update and skip decision
  function automatic logic is_zero(input logic [isbx_pkg::DATA_W-1:0] v);
    is_zero = (v == '0);
  endfunction

  // next sequential address; wraps at the top of the 15-bit space
  function automatic logic [isbx_pkg::PC_W-1:0] pc_inc(input logic [isbx_pkg::PC_W-1:0] p);
    pc_inc = p + 15'h0001;
  endfunction

  // ==========================================================
  // state
  isbx_pkg::isbx_state_t        st_q, st_d;     // execute state
  logic [isbx_pkg::DATA_W-1:0]  acc_q, acc_d;   // working register
  logic                         zero_q, zero_d; // zero flag
  logic [isbx_pkg::PC_W-1:0]    pc_q, pc_d;     // program counter

  isbx_wb_if wb ();                             // write-back to the port

  // ==========================================================
  // decode
  logic [5:0]                  op6;      // six opcode bits
  logic                        dest;     // destination select
  logic                        is_dsz;   // decrement, skip if zero
  logic                        is_isz;   // increment, skip if zero
  logic                        is_inc;   // increment file
  logic                        is_or;    // or literal into acc
  logic                        is_br;    // unconditional branch
  logic [isbx_pkg::DATA_W-1:0] res;      // arithmetic result
  logic                        run;      // executing a real word

  assign op6    = insn_i[isbx_pkg::INSN_W-1 -: 6];
  assign dest   = insn_i[isbx_pkg::DEST_BIT];
  // decode is qualified by run, so a discarded word decodes to nothing
  assign run    = insn_valid_i && (st_q == isbx_pkg::ISBX_ST_RUN);
  assign is_dsz = run && (op6 == isbx_pkg::OP_DEC_SKIP);
  assign is_isz = run && (op6 == isbx_pkg::OP_INC_SKIP);
  assign is_inc = run && (op6 == isbx_pkg::OP_INC_FILE);
  assign is_or  = run && (op6 == isbx_pkg::OP_OR_LIT);
  assign is_br  = run && (insn_i[isbx_pkg::INSN_W-1 -: 3] == isbx_pkg::OP_BRANCH);

  assign f_raddr_o = insn_i[isbx_pkg::FADR_W-1:0];

  // result: decrement for the decrement-skip, otherwise increment or or-literal
  always_comb
  begin
    // one result per word; the or path ignores the file contents
    if (is_dsz)
    begin
      res = f_rdata_i - 8'h01;
    end
    else if (is_or)
    begin
      res = acc_q | insn_i[isbx_pkg::DATA_W-1:0];
    end
    else
    begin
      res = f_rdata_i + 8'h01;
    end
  end

  // ==========================================================
  // execute next state
  always_comb
  begin
    // defaults: state back to run, hold the other registers, no file write
    st_d    = isbx_pkg::ISBX_ST_RUN;
    acc_d   = acc_q;
    zero_d  = zero_q;
    pc_d    = pc_q;
    wb.we   = 1'b0;
    wb.addr = insn_i[isbx_pkg::FADR_W-1:0];
    wb.data = res;
    case (st_q)
      isbx_pkg::ISBX_ST_RUN:
      begin
        if (is_br)
        begin
          // new pc from immediate and latch page; second cycle is empty
          // the page bits come from the latch every time; nothing old is kept
          pc_d = {upper_pc_latch_i[isbx_pkg::LATCH_HI:isbx_pkg::LATCH_LO],
                  insn_i[isbx_pkg::BRK_W-1:0]};
          st_d = isbx_pkg::ISBX_ST_NOP;
        end
        else if (is_dsz || is_isz || is_inc)
        begin
          // write to accumulator or back to the file
          if (dest)
          begin
            wb.we = 1'b1;
          end
          else
          begin
            acc_d = res;
          end
          // only the plain increment reports its result on the flag
          if (is_inc)
          begin
            zero_d = is_zero(res);
          end
          // skip variants leave flags alone; zero result empties the next slot
          if ((is_dsz || is_isz) && is_zero(res))
          begin
            st_d = isbx_pkg::ISBX_ST_NOP;
          end
          pc_d = pc_inc(pc_q);
        end
        else if (is_or)
        begin
          // literal path never touches the file
          acc_d  = res;
          zero_d = is_zero(res);
          pc_d   = pc_inc(pc_q);
        end
        else if (run)
        begin
          // other words belong elsewhere; just advance
          pc_d = pc_inc(pc_q);
        end
      end
      isbx_pkg::ISBX_ST_NOP:
      begin
        // discard the fetched word; advance past it, branch target or not
        st_d = isbx_pkg::ISBX_ST_RUN;
        if (insn_valid_i)
        begin
          pc_d = pc_inc(pc_q);
        end
        else
        begin
          // no word yet: keep the empty slot pending
          st_d = isbx_pkg::ISBX_ST_NOP;
        end
      end
      default:
      begin
        // unreachable code: fall back to executing
        st_d = isbx_pkg::ISBX_ST_RUN;
      end
    endcase
  end

  // ==========================================================
  // register execute state
  // reset puts the core at address zero with a clear accumulator and flag
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q   <= isbx_pkg::ISBX_ST_RUN;
      acc_q  <= isbx_pkg::ACC_RST;
      zero_q <= isbx_pkg::ZERO_RST;
      pc_q   <= isbx_pkg::PC_RST;
    end
    else
    begin
      st_q   <= st_d;
      acc_q  <= acc_d;
      zero_q <= zero_d;
      pc_q   <= pc_d;
    end
  end

  // ==========================================================
  // outputs
  assign acc_o      = acc_q;
  assign zero_o     = zero_q;
  assign pc_o       = pc_q;
  // every presented word is consumed, whether executed or discarded
  assign insn_ack_o = insn_valid_i;
  assign flush_o    = insn_valid_i && (st_q == isbx_pkg::ISBX_ST_NOP);

  // ==========================================================
  // file write-back register
  isbx_wb_port u_wb
  (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .wb        (wb),
    .f_we_o    (f_we_o),
    .f_waddr_o (f_waddr_o),
    .f_wdata_o (f_wdata_o)
  );

endmodule

// ### rtl/isbx_pkg.sv
// isbx_pkg: shared constants and types for the five-instruction execute block
// assumes: 8-bit data path, 15-bit program counter, 14-bit instruction words
package isbx_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W  = 8;           // data path width
  localparam int PC_W    = 15;          // program counter width
  localparam int INSN_W  = 14;          // instruction word width
  localparam int FADR_W  = 7;           // file register address width
  localparam int BRK_W   = 11;          // branch immediate width

  // ==========================================================
  // field positions inside the instruction word and the upper pc latch
  localparam int DEST_BIT     = 7;      // destination select bit
  localparam int LATCH_LO     = 3;      // low latch bit feeding the pc page
  localparam int LATCH_HI     = 6;      // high latch bit feeding the pc page

  // ==========================================================
  // opcode patterns (upper bits of the word)
  localparam logic [5:0] OP_DEC_SKIP = 6'h0b;  // decrement, skip if zero
  localparam logic [5:0] OP_INC_SKIP = 6'h0f;  // increment, skip if zero
  localparam logic [5:0] OP_INC_FILE = 6'h0a;  // increment file
  localparam logic [5:0] OP_OR_LIT   = 6'h38;  // or literal into acc
  localparam logic [2:0] OP_BRANCH   = 3'h5;   // unconditional branch (bits 13:11)

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;   // working register after reset
  localparam logic [PC_W-1:0]   PC_RST   = 15'h0000; // program counter after reset
  localparam logic              ZERO_RST = 1'b0;     // zero flag after reset

  // ==========================================================
  // execute state machine, one-hot
  typedef enum logic [1:0] {
    ISBX_ST_RUN  = 2'b01,               // executing the fetched word
    ISBX_ST_NOP  = 2'b10                // forced empty cycle (skip or branch)
  } isbx_state_t;

endpackage

// ### rtl/isbx_wb_if.sv
// isbx_wb_if: file write-back request carried from the core to the write port
// assumes: single clock, write happens on the clock edge
`timescale 1ns/10ps
interface isbx_wb_if;
  logic                            we;    // write request
  logic [isbx_pkg::FADR_W-1:0]     addr;  // file address
  logic [isbx_pkg::DATA_W-1:0]     data;  // value to write

  modport src (output we, output addr, output data);
  modport dst (input we, input addr, input data);
endinterface

// ### rtl/isbx_wb_port.sv
// isbx_wb_port: registers the file write-back onto the outer file bus
// assumes: the file memory outside takes one write per cycle
`timescale 1ns/10ps
module isbx_wb_port
(
  input  wire logic                        clk_i,     // core clock
  input  wire logic                        rst_b_i,   // async reset, active low
  isbx_wb_if.dst                           wb,        // request from the core
  output logic                             f_we_o,    // file write strobe
  output logic [isbx_pkg::FADR_W-1:0]      f_waddr_o, // file write address
  output logic [isbx_pkg::DATA_W-1:0]      f_wdata_o  // file write data
);

  // ==========================================================
  // next values
  logic                        we_d;
  logic [isbx_pkg::FADR_W-1:0] addr_d;
  logic [isbx_pkg::DATA_W-1:0] data_d;

  // pass request through; keep address and data when idle
  always_comb
  begin
    we_d   = wb.we;
    addr_d = wb.we ? wb.addr : f_waddr_o;
    data_d = wb.we ? wb.data : f_wdata_o;
  end

  // register the write-back
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      f_we_o    <= 1'b0;
      f_waddr_o <= '0;
      f_wdata_o <= '0;
    end
    else
    begin
      f_we_o    <= we_d;
      f_waddr_o <= addr_d;
      f_wdata_o <= data_d;
    end
  end

endmodule

// ### testbench/isbx_core_sva.sv
// isbx_core_sva: port-level timing checks of the five-instruction execute block
// assumes: bound onto isbx_core, one clock, reset asynchronous and active low
`timescale 1ns/10ps
module isbx_core_sva
(
  input wire logic        clk_i,            // core clock
  input wire logic        rst_b_i,          // reset, active low
  input wire logic        insn_valid_i,     // word valid
  input wire logic [13:0] insn_i,           // instruction word
  input wire logic [7:0]  f_rdata_i,        // file contents
  input wire logic [7:0]  upper_pc_latch_i, // upper pc latch
  input wire logic        f_we_o,           // file write strobe
  input wire logic [6:0]  f_waddr_o,        // file write address
  input wire logic [7:0]  acc_o,            // working register
  input wire logic        zero_o,           // zero flag
  input wire logic [14:0] pc_o,             // program counter
  input wire logic        flush_o           // discarded slot
);
  // ==========================================================
  // decode helpers
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire logic       take = insn_valid_i && !flush_o; // word executes
  wire logic [5:0] op   = insn_i[13:8];             // opcode field
  wire logic       skp  = op == isbx_pkg::OP_DEC_SKIP || op == isbx_pkg::OP_INC_SKIP;
  wire logic       hit  = (op == isbx_pkg::OP_DEC_SKIP) ? f_rdata_i == 8'h01 : f_rdata_i == 8'hff;
  sequence s_branch;
    take && insn_i[13:11] == isbx_pkg::OP_BRANCH;
  endsequence
  sequence s_skip_zero;
    take && skp && hit;
  endsequence

  // ==========================================================
  // properties
  branch_pc_a: assert property (s_branch |=> pc_o == {$past(upper_pc_latch_i[6:3]), $past(insn_i[10:0])})
    else $error("branch target wrong");
  branch_slot_a: assert property (s_branch ##1 insn_valid_i |-> flush_o)
    else $error("word after branch not discarded");
  branch_flags_a: assert property (s_branch |=> $stable(zero_o) && $stable(acc_o))
    else $error("branch changed flag or accumulator");
  skip_zero_a: assert property (s_skip_zero ##1 insn_valid_i |-> flush_o)
    else $error("zero result did not discard next word");
  skip_flag_a: assert property (take && skp |=> $stable(zero_o))
    else $error("skip instruction changed zero flag");
  no_skip_a: assert property (take && skp && !hit ##1 insn_valid_i |-> !flush_o)
    else $error("nonzero skip discarded next word");
  or_lit_a: assert property (take && op == isbx_pkg::OP_OR_LIT |=> acc_o == ($past(acc_o) | $past(insn_i[7:0])) && zero_o == (acc_o == 8'h00))
    else $error("or literal result wrong");
  inc_acc_a: assert property (take && op == isbx_pkg::OP_INC_FILE && !insn_i[7] |=> acc_o == $past(f_rdata_i) + 8'h01 && zero_o == (acc_o == 8'h00))
    else $error("increment into accumulator wrong");
  dest_file_a: assert property (take && (skp || op == isbx_pkg::OP_INC_FILE) && insn_i[7] |=> $stable(acc_o) && f_we_o && f_waddr_o == $past(insn_i[6:0]))
    else $error("file destination write missing");
  inc_no_skip_a: assert property (take && op == isbx_pkg::OP_INC_FILE ##1 insn_valid_i |-> !flush_o)
    else $error("increment discarded next word");
  pc_step_a: assert property (insn_valid_i && !(take && insn_i[13:11] == isbx_pkg::OP_BRANCH) |=> pc_o == $past(pc_o) + 15'h0001)
    else $error("program counter did not advance by one");
endmodule

bind isbx_core isbx_core_sva sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .insn_valid_i(insn_valid_i),
  .insn_i(insn_i), .f_rdata_i(f_rdata_i), .upper_pc_latch_i(upper_pc_latch_i), .f_we_o(f_we_o),
  .f_waddr_o(f_waddr_o), .acc_o(acc_o), .zero_o(zero_o), .pc_o(pc_o), .flush_o(flush_o));

// ### testbench/incdec_skip_branch_exec_tb.sv
// incdec_skip_branch_exec_tb: random and corner instruction streams with a reference model
// assumes: isbx_core as top, file contents driven by the bench alongside each word
`timescale 1ns/10ps
module incdec_skip_branch_exec_tb;
  // ==========================================================
  // stimulus and observed signals
  logic clk_i = 1'b0, rst_b_i = 1'b0, insn_valid_i = 1'b0, f_we_o, zero_o, insn_ack_o, flush_o;
  logic [13:0] insn_i = 14'h0000;
  logic [7:0]  f_rdata_i = 8'h00, upper_pc_latch_i = 8'h00, f_wdata_o, acc_o;
  logic [6:0]  f_raddr_o, f_waddr_o;
  logic [14:0] pc_o;
  // model state: accumulator, flag, pc, pending empty slot, write in flight
  logic [7:0]  m_acc = 8'h00, p_d = 8'h00;
  logic [14:0] m_pc = 15'h0000;
  logic        m_zero = 1'b0, m_nop = 1'b0, p_we = 1'b0;
  logic [6:0]  p_a = 7'h00;
  int          errors = 0, checks = 0;

  always #5 clk_i = ~clk_i;

  isbx_core dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
    .f_rdata_i(f_rdata_i), .upper_pc_latch_i(upper_pc_latch_i), .f_raddr_o(f_raddr_o),
    .f_we_o(f_we_o), .f_waddr_o(f_waddr_o), .f_wdata_o(f_wdata_o), .acc_o(acc_o),
    .zero_o(zero_o), .pc_o(pc_o), .insn_ack_o(insn_ack_o), .flush_o(flush_o));

  // ==========================================================
  // compare tasks and verdict
  task automatic cmp_val(input logic [14:0] got, input logic [14:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // single-bit results: flags and strobes
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // result of the arithmetic instructions
  function automatic logic [7:0] res(input logic [13:0] w, input logic [7:0] rd);
    return (w[13:8] == isbx_pkg::OP_DEC_SKIP) ? rd - 8'h01 : rd + 8'h01;
  endfunction

  // one word per edge: check the previous word's effect, then advance the model
  task automatic step(input logic v, input logic [13:0] w, input logic [7:0] rd, lat);
    logic [7:0] r;
    @(posedge clk_i);
    insn_valid_i <= v;
    insn_i <= w;
    f_rdata_i <= rd;
    upper_pc_latch_i <= lat;
    #1;
    r = res(w, rd);
    cmp_val(acc_o, m_acc);
    cmp_bit(zero_o, m_zero);
    cmp_val(pc_o, m_pc);
    cmp_bit(flush_o, m_nop & v);
    cmp_val({f_raddr_o, insn_ack_o}, {w[6:0], v});
    cmp_bit(f_we_o, p_we);
    if (p_we)
      cmp_val({f_waddr_o, f_wdata_o}, {p_a, p_d});
    p_we = 1'b0;
    if (v && m_nop)
      {m_pc, m_nop} = {m_pc + 15'h0001, 1'b0};
    else if (v && w[13:11] == isbx_pkg::OP_BRANCH)
      {m_pc, m_nop} = {lat[6:3], w[10:0], 1'b1};
    else if (v)
    begin
      m_pc = m_pc + 15'h0001;
      if (w[13:8] == isbx_pkg::OP_OR_LIT)
        {m_acc, m_zero} = {m_acc | w[7:0], (m_acc | w[7:0]) == 8'h00};
      else if (w[13:8] inside {isbx_pkg::OP_DEC_SKIP, isbx_pkg::OP_INC_SKIP, isbx_pkg::OP_INC_FILE})
      begin
        if (w[7])
          {p_we, p_a, p_d} = {1'b1, w[6:0], r};
        else
          m_acc = r;
        if (w[13:8] == isbx_pkg::OP_INC_FILE)
          m_zero = (r == 8'h00);
        else
          m_nop = (r == 8'h00);
      end
    end
  endtask

  // ==========================================================
  // watchdog
  initial
  begin
    #60000;
    errors++;
    report_and_stop();
  end

  // ==========================================================
  // main sequence: corners, then a random stream
  initial
  begin
    logic [5:0] ops [4];
    logic [7:0] rds [4];
    logic [13:0] w;
    ops = '{isbx_pkg::OP_DEC_SKIP, isbx_pkg::OP_INC_SKIP, isbx_pkg::OP_INC_FILE, isbx_pkg::OP_OR_LIT};
    rds = '{8'h00, 8'h01, 8'hff, 8'h7f};
    void'($urandom(32'hfc79));
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    step(1'b1, {isbx_pkg::OP_OR_LIT, 8'h00}, 8'h00, 8'h00);
    step(1'b1, {isbx_pkg::OP_DEC_SKIP, 8'h85}, 8'h01, 8'h00);
    step(1'b1, 14'h0000, 8'h00, 8'h00);
    step(1'b1, {isbx_pkg::OP_INC_SKIP, 8'h05}, 8'hff, 8'h00);
    step(1'b1, 14'h0000, 8'h00, 8'h00);
    step(1'b1, {isbx_pkg::OP_DEC_SKIP, 8'h05}, 8'h02, 8'h00);
    step(1'b1, {isbx_pkg::OP_OR_LIT, 8'h80}, 8'h00, 8'h00);
    step(1'b1, {isbx_pkg::OP_BRANCH, 11'h7ff}, 8'h00, 8'h78);
    step(1'b0, 14'h0000, 8'h00, 8'h00);
    step(1'b1, 14'h0000, 8'h00, 8'h00);
    step(1'b1, {isbx_pkg::OP_INC_FILE, 8'h81}, 8'hff, 8'h00);
    for (int i = 0; i < 400; i++)
    begin
      w = {ops[$urandom % 4], 8'($urandom)};
      if ($urandom % 5 == 0)
        w = {isbx_pkg::OP_BRANCH, 11'($urandom)};
      step(($urandom % 8) != 0, w, rds[$urandom % 4] ^ (8'($urandom) & {8{i[0]}}), 8'($urandom));
    end
    step(1'b0, 14'h0000, 8'h00, 8'h00);
    step(1'b0, 14'h0000, 8'h00, 8'h00);
    report_and_stop();
  end
endmodule
